// ===== logic/fdp_top.sv
`timescale 1ns/1ns
// Operation
// - ctrl read shows swap sense when gated
// - ops offset write loads whole byte
// - ctrl offset write loads two low bits
// - reset idles sequencer, enters base mode
// - count raw read falling edges as flux
// - alternate clock only for 300 kb/s rate
// - two-speed spindle never gets alternate clock
// - precomp 125 ns high, 187 ns low
// - defeat disables precomp, ignores select
// - side select high side 0
// - write gate low just before writing
// - write stream falling edge per transition
// - direction high outward, low inward
// - one low step pulse per track
// - pc mode selects a,b from ops bits
// - pc mode motor a from ops register
// - base/special: decoded active-low unit selects
// - motor b pc, else unit d
module fdp_top (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic media_swap_status_gate_n,
  input wire logic media_swap_sense_n,
  input wire logic raw_read_stream,
  input wire logic spindle_type_sel,
  input wire logic precomp_amount_sel,
  output logic alt_clock_select,
  output logic side_select,
  output logic write_gate_n,
  output logic write_pulse_stream,
  output logic step_direction,
  output logic step_pulse_n,
  output logic unit_select_a_n,
  output logic unit_select_b_n,
  output logic motor_a_or_unit_c_n,
  output logic motor_b_or_unit_d_n
);

  localparam int CELL_W = $clog2(fdp_pkg::BIT_CELL_CYC);
  localparam int LEAD_W = $clog2(fdp_pkg::GATE_LEAD_CYC + 1);
  localparam logic [CELL_W-1:0] CELL_LAST =
    CELL_W'(fdp_pkg::BIT_CELL_CYC - 1);
  localparam logic [LEAD_W-1:0] LEAD_DONE =
    LEAD_W'(fdp_pkg::GATE_LEAD_CYC);
  localparam logic [fdp_pkg::DELAY_W-1:0] DLY_SHORT =
    fdp_pkg::DELAY_W'(fdp_pkg::PRECOMP_SHORT_CYC);
  localparam logic [fdp_pkg::DELAY_W-1:0] DLY_LONG =
    fdp_pkg::DELAY_W'(fdp_pkg::PRECOMP_LONG_CYC);

  typedef struct packed {
    fdp_pkg::fdp_mode_type mode;
    fdp_pkg::fdp_wr_type wstate;
    logic [7:0] ops;
    logic [1:0] ctrl;
    logic [fdp_pkg::CMD_W-1:0] cmd;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic [CELL_W-1:0] cellcnt;
    logic [LEAD_W-1:0] leadcnt;
    logic [15:0] flux;
    logic raw_prev;
    logic waitreq;
    logic [31:0] rdata;
    logic alt_sel;
    logic [3:0] sel_n;
  } fdp_top_state_type;

  fdp_top_state_type s;
  fdp_top_state_type next_s;
  logic [fdp_pkg::PIN_W-1:0] pins;
  logic gate_q;
  logic swap_q;
  logic raw_q;
  logic spin_q;
  logic pc_q;
  logic step_trig;
  logic step_busy;
  logic wr_trig;
  logic wr_busy;
  logic [fdp_pkg::DELAY_W-1:0] wr_delay;
  logic blocked;
  logic accept;
  logic gate_ok;
  logic [3:0] unit_dec_n;

  initial begin
    if (fdp_pkg::BIT_CELL_CYC <= fdp_pkg::PRECOMP_LONG_CYC +
        fdp_pkg::WRITE_PULSE_CYC + 1) begin
      $error("fdp_top: bit cell too short for precomp and pulse");
    end
  end

  // ---------------------------------------------------------------
  // pin synchroniser and pulse generators
  // ---------------------------------------------------------------
  fdp_sync #(
    .W(fdp_pkg::PIN_W),
    .RST_VAL('1)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin_in({precomp_amount_sel, spindle_type_sel, raw_read_stream,
             media_swap_sense_n, media_swap_status_gate_n}),
    .level(pins)
  );

  assign gate_q = pins[fdp_pkg::PIN_GATE];
  assign swap_q = pins[fdp_pkg::PIN_SWAP];
  assign raw_q = pins[fdp_pkg::PIN_RAW];
  assign spin_q = pins[fdp_pkg::PIN_SPIN];
  assign pc_q = pins[fdp_pkg::PIN_PRECOMP];

  fdp_pulse #(
    .WIDTH_CYC(fdp_pkg::STEP_PULSE_CYC),
    .DW(fdp_pkg::DELAY_W)
  ) u_step (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .trigger(step_trig),
    .delay('0),
    .pulse_n(step_pulse_n),
    .busy(step_busy)
  );

  // every falling edge of the stream is one recorded transition
  // write transition pulse
  fdp_pulse #(
    .WIDTH_CYC(fdp_pkg::WRITE_PULSE_CYC),
    .DW(fdp_pkg::DELAY_W)
  ) u_wpulse (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .trigger(wr_trig),
    .delay(wr_delay),
    .pulse_n(write_pulse_stream),
    .busy(wr_busy)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  assign gate_ok = s.cmd[fdp_pkg::CMD_GATE] && (s.leadcnt == LEAD_DONE);
  assign blocked = avs_write &&
    (((avs_address == fdp_pkg::OFS_DATA) && (s.wstate != fdp_pkg::WR_IDLE))
     || ((avs_address == fdp_pkg::OFS_CMD) &&
         avs_writedata[fdp_pkg::CMD_STEP] && step_busy));
  assign accept = !s.waitreq && (avs_read || avs_write);

  always_comb begin
    next_s = s;
    step_trig = 1'b0;
    wr_trig = 1'b0;
    wr_delay = '0;
    unit_dec_n = '1;
    // flux transitions from the drive
    // falling edge count
    next_s.raw_prev = raw_q;
    if (s.raw_prev && !raw_q) begin
      next_s.flux = s.flux + 16'h0001;
    end
    // bus handshake: one wait cycle, action at the sampled edge
    if (s.waitreq) begin
      if ((avs_read || avs_write) && !blocked) begin
        next_s.waitreq = 1'b0;
      end
      case (avs_address)
        fdp_pkg::OFS_OPS: begin
          next_s.rdata = 32'(s.ops);
        end
        fdp_pkg::OFS_CTRL: begin
          next_s.rdata = 32'(s.ctrl);
          if (!gate_q) begin
            next_s.rdata[fdp_pkg::CTRL_SWAP_BIT] = swap_q;
          end
        end
        fdp_pkg::OFS_STATUS: begin
          next_s.rdata = 32'({s.mode, step_busy, wr_busy,
            (s.wstate == fdp_pkg::WR_SHIFT), gate_ok, spin_q, pc_q});
        end
        fdp_pkg::OFS_CMD: begin
          next_s.rdata = 32'(s.cmd);
        end
        fdp_pkg::OFS_DATA: begin
          next_s.rdata = 32'(s.shreg);
        end
        fdp_pkg::OFS_FLUX: begin
          next_s.rdata = 32'(s.flux);
        end
        default: begin
          next_s.rdata = '0;
        end
      endcase
    end else begin
      next_s.waitreq = 1'b1;
    end
    if (accept && avs_write) begin
      case (avs_address)
        fdp_pkg::OFS_OPS: begin
          next_s.ops = avs_writedata[7:0];
        end
        fdp_pkg::OFS_CTRL: begin
          next_s.ctrl = avs_writedata[1:0];
        end
        fdp_pkg::OFS_CMD: begin
          next_s.cmd = avs_writedata[fdp_pkg::CMD_W-1:0];
          next_s.cmd[fdp_pkg::CMD_STEP] = 1'b0;
          step_trig = avs_writedata[fdp_pkg::CMD_STEP];
          case (avs_writedata[fdp_pkg::CMD_MODE +: 2])
            fdp_pkg::MODE_CODE_PC: begin
              next_s.mode = fdp_pkg::MODE_PC;
            end
            fdp_pkg::MODE_CODE_SPECIAL: begin
              next_s.mode = fdp_pkg::MODE_SPECIAL;
            end
            default: begin
              next_s.mode = fdp_pkg::MODE_BASE;
            end
          endcase
        end
        fdp_pkg::OFS_DATA: begin
          if (gate_ok) begin
            next_s.shreg = avs_writedata[7:0];
            next_s.bitcnt = 3'h7;
            next_s.cellcnt = '0;
            next_s.wstate = fdp_pkg::WR_SHIFT;
          end
        end
        default: begin
        end
      endcase
    end
    // write gate lead time before the first cell
    // gate lead count
    if (!s.cmd[fdp_pkg::CMD_GATE]) begin
      next_s.leadcnt = '0;
    end else if (s.leadcnt != LEAD_DONE) begin
      next_s.leadcnt = s.leadcnt + 1'b1;
    end
    // serial write shifter
    case (s.wstate)
      fdp_pkg::WR_IDLE: begin
      end
      fdp_pkg::WR_SHIFT: begin
        if (!s.cmd[fdp_pkg::CMD_GATE]) begin
          next_s.wstate = fdp_pkg::WR_IDLE;
        end else begin
          if (s.cellcnt == '0) begin
            wr_trig = s.shreg[7];
          end
          if (s.cellcnt == CELL_LAST) begin
            next_s.cellcnt = '0;
            next_s.shreg = {s.shreg[6:0], 1'b0};
            next_s.bitcnt = s.bitcnt - 3'h1;
            if (s.bitcnt == 3'h0) begin
              next_s.wstate = fdp_pkg::WR_IDLE;
            end
          end else begin
            next_s.cellcnt = s.cellcnt + 1'b1;
          end
        end
      end
      default: begin
        next_s.wstate = fdp_pkg::WR_IDLE;
      end
    endcase
    // inner track precompensation
    // precomp amount
    if (s.cmd[fdp_pkg::CMD_INNER] && !s.cmd[fdp_pkg::CMD_DEFEAT]) begin
      wr_delay = pc_q ? DLY_SHORT : DLY_LONG;
    end
    // clock source choice
    // alternate for 300 kb/s
    next_s.alt_sel = (s.ctrl == fdp_pkg::RATE_ALT) && spin_q;
    // drive and motor selects
    // decoded unit selects
    if (s.cmd[fdp_pkg::CMD_UNIT_EN]) begin
      unit_dec_n = ~(4'h1 << s.cmd[fdp_pkg::CMD_UNIT +: 2]);
    end
    if (s.mode == fdp_pkg::MODE_PC) begin
      next_s.sel_n[0] = ~s.ops[fdp_pkg::OPS_SEL_A];
      next_s.sel_n[1] = ~s.ops[fdp_pkg::OPS_SEL_B];
      next_s.sel_n[2] = ~s.ops[fdp_pkg::OPS_MOTOR_A];
      next_s.sel_n[3] = ~s.ops[fdp_pkg::OPS_MOTOR_B];
    end else begin
      next_s.sel_n = unit_dec_n;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // base mode, idle sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{mode: fdp_pkg::MODE_BASE, wstate: fdp_pkg::WR_IDLE,
             ops: '0, ctrl: '0, cmd: fdp_pkg::CMD_RST, shreg: '0,
             bitcnt: '0, cellcnt: '0, leadcnt: '0, flux: '0,
             raw_prev: 1'b1, waitreq: 1'b1, rdata: '0,
             alt_sel: 1'b0, sel_n: '1};
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign alt_clock_select = s.alt_sel;
  assign side_select = ~s.cmd[fdp_pkg::CMD_SIDE];
  assign step_direction = s.cmd[fdp_pkg::CMD_DIR];
  assign write_gate_n = ~s.cmd[fdp_pkg::CMD_GATE];
  assign unit_select_a_n = s.sel_n[0];
  assign unit_select_b_n = s.sel_n[1];
  assign motor_a_or_unit_c_n = s.sel_n[2];
  assign motor_b_or_unit_d_n = s.sel_n[3];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence wr_ack(logic [4:0] ofs);
    !avs_waitrequest && avs_write && (avs_address == ofs);
  endsequence

  AST_SWAP_READ: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !avs_waitrequest && avs_read && (avs_address == fdp_pkg::OFS_CTRL)
    && !$past(gate_q) |-> avs_readdata[7] == $past(swap_q))
    else $error("swap sense not on bit 7");

  AST_OPS_LOAD: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    wr_ack(fdp_pkg::OFS_OPS) |=> s.ops == $past(avs_writedata[7:0]))
    else $error("ops byte not loaded");

  AST_CTRL_LOAD: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    wr_ack(fdp_pkg::OFS_CTRL) |=> s.ctrl == $past(avs_writedata[1:0]))
    else $error("ctrl bits not loaded");

  AST_RESET_STATE: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(rst_b) |-> s.mode == fdp_pkg::MODE_BASE &&
    s.wstate == fdp_pkg::WR_IDLE)
    else $error("not idle in base mode after reset");

  AST_FLUX_COUNT: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    s.raw_prev && !raw_q |=> s.flux == $past(s.flux) + 16'h0001)
    else $error("flux edge not counted");

  AST_ALT_CLOCK: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !spin_q |=> !alt_clock_select)
    else $error("alternate clock with two-speed spindle");

  AST_PRECOMP: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    wr_trig && s.cmd[fdp_pkg::CMD_INNER] && !s.cmd[fdp_pkg::CMD_DEFEAT]
    |-> wr_delay == (pc_q ? DLY_SHORT : DLY_LONG))
    else $error("wrong precomp amount");

  AST_DEFEAT: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    wr_trig && s.cmd[fdp_pkg::CMD_DEFEAT] |-> wr_delay == '0)
    else $error("precomp not defeated");

  AST_GATE_FIRST: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    wr_trig |-> !write_gate_n && $past(!write_gate_n, 1))
    else $error("write pulse without gate lead");

  AST_PC_SELECT: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    s.mode == fdp_pkg::MODE_PC ##1 s.mode == fdp_pkg::MODE_PC
    |-> unit_select_a_n == !$past(s.ops[fdp_pkg::OPS_SEL_A]))
    else $error("pc select not from ops register");

  AST_RESET_HIGH: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(rst_b) |-> write_gate_n && step_pulse_n && (&s.sel_n))
    else $error("active-low outputs not idle after reset");

endmodule

// ===== pkg/fdp_pkg.sv
package fdp_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int PRECOMP_SHORT_NS = 125;
  localparam int PRECOMP_LONG_NS = 187;
  localparam int PRECOMP_SHORT_CYC = (PRECOMP_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRECOMP_LONG_CYC = (PRECOMP_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_PULSE_NS = 1000;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_PULSE_NS = 200;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GATE_LEAD_NS = 400;
  localparam int GATE_LEAD_CYC = (GATE_LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIT_CELL_NS = 2000;
  localparam int BIT_CELL_CYC = BIT_CELL_NS / CLK_NS;
  localparam int DELAY_W = 3;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_OPS = 5'h00;
  localparam logic [4:0] OFS_CTRL = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_CMD = 5'h0c;
  localparam logic [4:0] OFS_DATA = 5'h10;
  localparam logic [4:0] OFS_FLUX = 5'h14;

  // ---------------------------------------------------------------
  // fields
  // ---------------------------------------------------------------
  localparam int OPS_SEL_A = 0;
  localparam int OPS_SEL_B = 1;
  localparam int OPS_MOTOR_A = 4;
  localparam int OPS_MOTOR_B = 5;
  localparam logic [1:0] RATE_ALT = 2'h1;
  localparam int CTRL_SWAP_BIT = 7;
  localparam int CMD_W = 11;
  localparam int CMD_UNIT = 0;
  localparam int CMD_SIDE = 2;
  localparam int CMD_DIR = 3;
  localparam int CMD_MODE = 4;
  localparam int CMD_DEFEAT = 6;
  localparam int CMD_INNER = 7;
  localparam int CMD_STEP = 8;
  localparam int CMD_GATE = 9;
  localparam int CMD_UNIT_EN = 10;
  localparam logic [CMD_W-1:0] CMD_RST = 11'h008;
  localparam logic [1:0] MODE_CODE_PC = 2'h1;
  localparam logic [1:0] MODE_CODE_SPECIAL = 2'h2;

  // pin bundle order into the synchroniser
  localparam int PIN_GATE = 0;
  localparam int PIN_SWAP = 1;
  localparam int PIN_RAW = 2;
  localparam int PIN_SPIN = 3;
  localparam int PIN_PRECOMP = 4;
  localparam int PIN_W = 5;

  typedef enum logic [1:0] {MODE_BASE, MODE_PC, MODE_SPECIAL} fdp_mode_type;
  typedef enum logic {WR_IDLE, WR_SHIFT} fdp_wr_type;

endpackage

// ===== logic/fdp_sync.sv
`timescale 1ns/1ns
module fdp_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } fdp_sync_state_type;

  fdp_sync_state_type s;
  fdp_sync_state_type next_s;
  logic [W-1:0] next_q;

  initial begin
    if (W < 1) begin
      $error("fdp_sync: W must be at least 1");
    end
  end

  // ---------------------------------------------------------------
  // per bit: accept a change once stages two and three agree
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign next_q[i] = (s.s2[i] == s.s3[i]) ? s.s3[i] : s.q[i];
    end
  endgenerate

  always_comb begin
    next_s = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.q = next_q;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.q;

endmodule

// ===== logic/fdp_pulse.sv
`timescale 1ns/1ns
module fdp_pulse #(
  parameter int WIDTH_CYC = 25,
  parameter int DW = 3
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic trigger,
  input wire logic [DW-1:0] delay,
  output logic pulse_n,
  output logic busy
);

  localparam int CW = $clog2(WIDTH_CYC + 1);
  localparam int PW_M1 = WIDTH_CYC - 1;

  typedef struct packed {
    logic [DW-1:0] dcnt;
    logic [CW-1:0] wcnt;
    logic low;
    logic pulse_n;
    logic busy;
  } fdp_pulse_state_type;

  fdp_pulse_state_type s;
  fdp_pulse_state_type next_s;

  initial begin
    if (WIDTH_CYC < 1 || DW < 1) begin
      $error("fdp_pulse: width and delay width must be at least 1");
    end
  end

  // ---------------------------------------------------------------
  // delayed one-shot, active low
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (!s.busy) begin
      if (trigger) begin
        next_s.busy = 1'b1;
        next_s.low = 1'b0;
        next_s.dcnt = delay;
      end
    end else if (!s.low) begin
      if (s.dcnt == '0) begin
        next_s.low = 1'b1;
        next_s.pulse_n = 1'b0;
        next_s.wcnt = CW'(PW_M1);
      end else begin
        next_s.dcnt = s.dcnt - 1'b1;
      end
    end else if (s.wcnt == '0) begin
      next_s.pulse_n = 1'b1;
      next_s.busy = 1'b0;
      next_s.low = 1'b0;
    end else begin
      next_s.wcnt = s.wcnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{dcnt: '0, wcnt: '0, low: 1'b0, pulse_n: 1'b1, busy: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign pulse_n = s.pulse_n;
  assign busy = s.busy;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence low_run;
    ##PW_M1 !pulse_n ##1 pulse_n;
  endsequence

  AST_PULSE_WIDTH: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $fell(pulse_n) |-> low_run)
    else $error("low pulse width wrong");

endmodule

// ===== tb/fdp_drive_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// drive side model
// ---------------------------------------------------------------
module fdp_drive_model (
  input wire logic sys_clk,
  input wire logic door_open,
  input wire logic flux_go,
  input wire logic write_gate_n,
  input wire logic write_pulse_stream,
  input wire logic step_pulse_n,
  output logic media_swap_sense_n,
  output logic raw_read_stream,
  output int cyc,
  output int wr_falls,
  output int wr_fall_cyc,
  output int step_falls,
  output int step_low,
  output logic gate_err
);
  int low_cnt;
  initial begin
    cyc = 0;
    wr_falls = 0;
    wr_fall_cyc = 0;
    step_falls = 0;
    step_low = 0;
    low_cnt = 0;
    gate_err = 1'b0;
    raw_read_stream = 1'b1;
  end
  assign media_swap_sense_n = door_open ? 1'b0 : 1'b1;
  // flux bursts of six transitions
  always @(posedge flux_go) begin
    repeat (6) begin
      repeat (8) @(posedge sys_clk);
      raw_read_stream <= 1'b0;
      repeat (4) @(posedge sys_clk);
      raw_read_stream <= 1'b1;
    end
  end
  // step pulse count and width
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (step_pulse_n === 1'b0) begin
      low_cnt <= low_cnt + 1;
    end else if (low_cnt != 0) begin
      step_low <= low_cnt;
      low_cnt <= 0;
    end
  end
  always @(negedge step_pulse_n) begin
    step_falls <= step_falls + 1;
  end
  // write transitions, only under gate
  always @(negedge write_pulse_stream) begin
    wr_falls = wr_falls + 1;
    wr_fall_cyc = cyc;
    if (write_gate_n !== 1'b0) begin
      gate_err = 1'b1;
    end
  end
endmodule

// ===== tb/fdp_top_test.sv
`timescale 1ns/1ns
module fdp_top_test;
  logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic gate_n, swap_n, raw, spin, pcsel, door, flux_go, gate_err;
  logic alt, side, wg_n, wps, dir, step_n, sa_n, sb_n, sc_n, sd_n;
  logic [3:0] sel;
  int mismatches, samples_checked, cyc, wr_falls, wr_fall_cyc;
  int step_falls, step_low, t0, base, n0;
  logic [31:0] pcmd [5] = '{32'h000, 32'h080, 32'h080, 32'h0c0, 32'h0c0};
  logic psel [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  int pext [5] = '{0, fdp_pkg::PRECOMP_SHORT_CYC,
    fdp_pkg::PRECOMP_LONG_CYC, 0, 0};
  logic [7:0] ops_v [6] = '{8'h00, 8'h33, 8'h01, 8'h02, 8'h10, 8'h20};
  assign sel = {sa_n, sb_n, sc_n, sd_n};

  fdp_top i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .media_swap_status_gate_n(gate_n),
    .media_swap_sense_n(swap_n), .raw_read_stream(raw),
    .spindle_type_sel(spin), .precomp_amount_sel(pcsel),
    .alt_clock_select(alt), .side_select(side), .write_gate_n(wg_n),
    .write_pulse_stream(wps), .step_direction(dir), .step_pulse_n(step_n),
    .unit_select_a_n(sa_n), .unit_select_b_n(sb_n),
    .motor_a_or_unit_c_n(sc_n), .motor_b_or_unit_d_n(sd_n)
  );
  fdp_drive_model i_drive (
    .sys_clk(sys_clk), .door_open(door), .flux_go(flux_go),
    .write_gate_n(wg_n), .write_pulse_stream(wps), .step_pulse_n(step_n),
    .media_swap_sense_n(swap_n), .raw_read_stream(raw), .cyc(cyc),
    .wr_falls(wr_falls), .wr_fall_cyc(wr_fall_cyc),
    .step_falls(step_falls), .step_low(step_low), .gate_err(gate_err)
  );

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(negedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 1000);
    @(posedge sys_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 1000) chk("bus answer", 0, 1);
    @(posedge sys_clk);
  endtask
  task automatic rd(input string what, input logic [4:0] a,
    input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, q & m);
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {gate_n, spin, pcsel, door, flux_go} = 5'b11100;
    mismatches = 0;
    samples_checked = 0;
    wt(10);
    chk("reset pins", 32'h1ff, {22'h0, alt, side, wg_n, wps, dir, step_n, sel});
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd("mode", fdp_pkg::OFS_STATUS, 32'hc0, 32'h0);
    rd("cmd", fdp_pkg::OFS_CMD, 32'h7ff, 32'h008);
    rd("unmapped", 5'h18, '1, 32'h0);
    $display("test reset finished");
    bus(1'b1, fdp_pkg::OFS_OPS, 32'hffff_ff5a);
    rd("ops", fdp_pkg::OFS_OPS, '1, 32'h5a);
    bus(1'b1, fdp_pkg::OFS_CTRL, 32'hff);
    rd("ctrl", fdp_pkg::OFS_CTRL, '1, 32'h3);
    for (int i = 0; i < 4; i++) begin
      gate_n <= i[1];
      door <= i[0];
      wt(8);
      rd("swap", fdp_pkg::OFS_CTRL, 32'h80, (i == 0) ? 32'h80 : 32'h0);
    end
    door <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      spin <= i[2];
      bus(1'b1, fdp_pkg::OFS_CTRL, 32'(i[1:0]));
      wt(8);
      chk("alt clock", 32'(i[2] && i[1:0] == 2'h1), alt);
    end
    spin <= 1'b1;
    $display("test registers finished");
    bus(1'b1, fdp_pkg::OFS_CMD, 32'h010);
    rd("pc mode", fdp_pkg::OFS_STATUS, 32'hc0, 32'h40);
    foreach (ops_v[i]) begin
      bus(1'b1, fdp_pkg::OFS_OPS, 32'(ops_v[i]));
      wt(3);
      chk("pc sel", {ops_v[i][0], ops_v[i][1], ops_v[i][4], ops_v[i][5]} ^ 4'hf, sel);
    end
    for (int u = 0; u < 4; u++) begin
      bus(1'b1, fdp_pkg::OFS_CMD, 32'h400 | (u == 1 ? 32'h20 : u == 3 ? 32'h30 : 0) | u);
      wt(3);
      chk("unit sel", 4'hf ^ (4'h8 >> u), sel);
    end
    bus(1'b1, fdp_pkg::OFS_CMD, 32'h002);
    wt(3);
    chk("no unit", 32'hf, sel);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, fdp_pkg::OFS_CMD, i << 2);
      wt(3);
      chk("side", 32'(!i[0]), side);
      chk("dir", 32'(i[1]), dir);
    end
    $display("test selects finished");
    n0 = step_falls;
    for (int i = 0; i < 3; i++) bus(1'b1, fdp_pkg::OFS_CMD, 32'h108);
    wt(60);
    chk("steps", n0 + 3, step_falls);
    chk("step width", fdp_pkg::STEP_PULSE_CYC, step_low);
    bus(1'b0, fdp_pkg::OFS_FLUX, 32'h0);
    base = q;
    flux_go <= 1'b1;
    wt(120);
    flux_go <= 1'b0;
    rd("flux", fdp_pkg::OFS_FLUX, 32'hffff, (base + 6) & 32'hffff);
    $display("test step and flux finished");
    for (int i = 0; i < 5; i++) begin
      pcsel <= psel[i];
      bus(1'b1, fdp_pkg::OFS_CMD, 32'h200 | pcmd[i]);
      wt(15);
      chk("gate", 32'h0, wg_n);
      n0 = wr_falls;
      bus(1'b1, fdp_pkg::OFS_DATA, 32'h80);
      t0 = cyc;
      wt(450);
      chk("one pulse", n0 + 1, wr_falls);
      if (i == 0) base = wr_fall_cyc - t0;
      chk("precomp", base + pext[i], wr_fall_cyc - t0);
    end
    n0 = wr_falls;
    bus(1'b1, fdp_pkg::OFS_DATA, 32'ha5);
    wt(450);
    chk("pulses", n0 + 4, wr_falls);
    bus(1'b1, fdp_pkg::OFS_CMD, 32'h000);
    wt(3);
    chk("gate off", 32'h1, wg_n);
    n0 = wr_falls;
    bus(1'b1, fdp_pkg::OFS_DATA, 32'hff);
    wt(450);
    chk("no gate", n0, wr_falls);
    chk("gate order", 32'h0, gate_err);
    $display("test write finished");
    close_out();
  end

  initial begin
    wt(20000);
    mismatches++;
    close_out();
  end
endmodule
